// >>> shared/twrs_consts.svh
// Constants for the two-wire register slave and its bus master
`ifndef TWRS_CONSTS_SVH
`define TWRS_CONSTS_SVH
`define TWRS_ADDR_BASE   7'h10
`define TWRS_SEL_STEP    7'h08
`define TWRS_BYTE_BITS   4'h8
`define TWRS_PHASE_HI    2'h0
`define TWRS_PHASE_LO    2'h1
`define TWRS_PHASE_DATA  2'h2
`define TWRS_PTR_RESET   16'h0000
`define TWRS_CLK_NS      100
`define TWRS_EXT_NS      64
`define TWRS_HIGH_EXT    8
`define TWRS_LOW_EXT     6
`define TWRS_QTR_NS      1000
`define TWRS_QTR_CYC     ((`TWRS_QTR_NS + `TWRS_CLK_NS - 1) / `TWRS_CLK_NS)
`endif

// >>> shared/twrs_pkg.sv
// Types shared by both ends of the two-wire register link
package twrs_pkg;
	typedef logic [7:0]  twrs_byte_t;
	typedef logic [15:0] twrs_addr_t;
	typedef enum logic [6:0] {
		D_IDLE = 7'h01,
		D_ADDR = 7'h02,
		D_ACK  = 7'h04,
		D_RX   = 7'h08,
		D_TX   = 7'h10,
		D_MACK = 7'h20,
		D_IGN  = 7'h40
	} twrs_dstate_t;
	typedef enum logic [3:0] {
		M_IDLE  = 4'h1,
		M_START = 4'h2,
		M_BYTE  = 4'h4,
		M_STOP  = 4'h8
	} twrs_mstate_t;
	typedef enum logic [5:0] {
		K_DEVW = 6'h01,
		K_HI   = 6'h02,
		K_LO   = 6'h04,
		K_WD   = 6'h08,
		K_DEVR = 6'h10,
		K_RD   = 6'h20
	} twrs_kind_t;
endpackage : twrs_pkg

// >>> shared/twrs_if.sv
// Two-wire link carrier resolving the open-drain wire levels
`timescale 1ns/1ps
interface twrs_if;
	logic scl_o;
	logic scl_oe_n;
	logic sda_m_o;
	logic sda_m_oe_n;
	logic sda_d_o;
	logic sda_d_oe_n;
	logic scl;
	logic sda;
	// Pull-up wins when nobody drives
	assign scl = scl_oe_n ? 1'h1 : scl_o;
	assign sda = (sda_m_oe_n ? 1'h1 : sda_m_o) & (sda_d_oe_n ? 1'h1 : sda_d_o);
	modport master (output scl_o, output scl_oe_n, output sda_m_o, output sda_m_oe_n,
		input sda);
	modport device (input scl, input sda, output sda_d_o, output sda_d_oe_n);
endinterface : twrs_if

// >>> hdl/twrs_master.sv
// Two-wire bus master issuing register writes and reads
`timescale 1ns/1ps
`include "twrs_consts.svh"
module twrs_master #(
	parameter int QTR = `TWRS_QTR_CYC
) (
	input  wire logic              clock,
	input  wire logic              rst,
	twrs_if.master                 bus,
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire logic              cmd_read,
	input  wire logic              cmd_random,
	input  wire logic [6:0]        cmd_dev,
	input  wire twrs_pkg::twrs_addr_t cmd_reg,
	input  wire logic [7:0]        cmd_len,
	input  wire twrs_pkg::twrs_byte_t wr_data,
	output logic                   wr_take,
	output twrs_pkg::twrs_byte_t   rd_data,
	output logic                   rd_valid,
	output logic                   done,
	output logic                   nack_err
);
	import twrs_pkg::*;

	twrs_mstate_t st_q, st_d;
	twrs_kind_t   kind_q, kind_d;
	logic [7:0]   tq_q, tq_d, left_q, left_d;
	logic [1:0]   qt_q, qt_d;
	logic [3:0]   b_q, b_d;
	twrs_byte_t   sh_q, sh_d, rdat_q, rdat_d;
	twrs_addr_t   reg_q, reg_d;
	logic [6:0]   dev_q, dev_d;
	logic         rd_q, rd_d, scl_q, scl_d, sda_q, sda_d;
	logic         rdy_q, rdy_d, take_q, take_d, rdv_q, rdv_d, done_q, done_d, err_q, err_d;
	logic         sda_m, sda_s, tick;

	// Line level is a pin from the far end
	always_ff @(posedge clock) begin
		sda_m <= bus.sda;
		sda_s <= sda_m;
	end

	// Two quarters per clock phase keep high and low long enough
	assign tick = (tq_q == 8'(QTR - 1));

	always_comb begin
		st_d = st_q; kind_d = kind_q; left_d = left_q; qt_d = qt_q; b_d = b_q;
		sh_d = sh_q; rdat_d = rdat_q; reg_d = reg_q; dev_d = dev_q; rd_d = rd_q;
		scl_d = scl_q; sda_d = sda_q; rdy_d = rdy_q; err_d = err_q;
		take_d = 1'h0; rdv_d = 1'h0; done_d = 1'h0;
		tq_d = tick ? 8'h00 : tq_q + 8'h01;
		if (st_q == M_IDLE) begin
			tq_d = 8'h00;
			if (cmd_valid && rdy_q) begin
				st_d = M_START; qt_d = 2'h0; rdy_d = 1'h0; err_d = 1'h0;
				rd_d = cmd_read; dev_d = cmd_dev; reg_d = cmd_reg; left_d = cmd_len;
				// Dummy write of the address precedes a random read
				kind_d = (cmd_read && !cmd_random) ? K_DEVR : K_DEVW;
			end
		end else if (tick) begin
			qt_d = qt_q + 2'h1;
			case (st_q)
				M_START: begin
					case (qt_q)
						2'h0: sda_d = 1'h1;
						2'h1: scl_d = 1'h1;
						2'h2: sda_d = 1'h0; // Fall while clock high
						default: begin
							scl_d = 1'h0; st_d = M_BYTE; b_d = 4'h0;
							sh_d = {dev_q, kind_q == K_DEVR};
						end
					endcase
				end
				M_BYTE: begin
					case (qt_q)
						2'h0: begin
							// Data moves only while clock low
							if (b_q == `TWRS_BYTE_BITS)
								sda_d = (kind_q == K_RD) ? (left_q == 8'h01) : 1'h1;
							else
								sda_d = (kind_q == K_RD) ? 1'h1 : sh_q[7]; // MSB first
						end
						2'h1: scl_d = 1'h1;
						2'h2: ;
						default: begin
							scl_d = 1'h0;
							if (b_q != `TWRS_BYTE_BITS) begin
								sh_d = {sh_q[6:0], sda_s};
								b_d = b_q + 4'h1;
							end else begin
								b_d = 4'h0;
								st_d = M_BYTE;
								if (kind_q != K_RD && sda_s) begin
									st_d = M_STOP; err_d = 1'h1;
								end else begin
									case (kind_q)
										K_DEVW: begin
											kind_d = K_HI; sh_d = reg_q[15:8];
										end
										K_HI: begin
											kind_d = K_LO; sh_d = reg_q[7:0];
										end
										K_LO, K_WD: begin
											if (rd_q) begin
												kind_d = K_DEVR; st_d = M_START;
											end else if (kind_q == K_WD && left_q == 8'h01) begin
												st_d = M_STOP;
											end else begin
												kind_d = K_WD; sh_d = wr_data; take_d = 1'h1;
												left_d = (kind_q == K_WD) ? left_q - 8'h01 : left_q;
											end
										end
										K_DEVR: kind_d = K_RD;
										default: begin
											rdat_d = sh_q; rdv_d = 1'h1; left_d = left_q - 8'h01;
											if (left_q == 8'h01)
												st_d = M_STOP;
										end
									endcase
								end
							end
						end
					endcase
				end
				M_STOP: begin
					case (qt_q)
						2'h0: sda_d = 1'h0;
						2'h1: scl_d = 1'h1;
						2'h2: sda_d = 1'h1; // Rise while clock high
						default: begin
							st_d = M_IDLE; rdy_d = 1'h1; done_d = 1'h1;
						end
					endcase
				end
				default: st_d = M_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_q <= M_IDLE; kind_q <= K_DEVW; tq_q <= 8'h00; left_q <= 8'h00;
			qt_q <= 2'h0; b_q <= 4'h0; sh_q <= 8'h00; rdat_q <= 8'h00;
			reg_q <= 16'h0000; dev_q <= 7'h00; rd_q <= 1'h0;
			scl_q <= 1'h1; sda_q <= 1'h1; rdy_q <= 1'h1; take_q <= 1'h0;
			rdv_q <= 1'h0; done_q <= 1'h0; err_q <= 1'h0;
		end else begin
			st_q <= st_d; kind_q <= kind_d; tq_q <= tq_d; left_q <= left_d;
			qt_q <= qt_d; b_q <= b_d; sh_q <= sh_d; rdat_q <= rdat_d;
			reg_q <= reg_d; dev_q <= dev_d; rd_q <= rd_d;
			scl_q <= scl_d; sda_q <= sda_d; rdy_q <= rdy_d; take_q <= take_d;
			rdv_q <= rdv_d; done_q <= done_d; err_q <= err_d;
		end
	end

	assign bus.scl_o      = scl_q;
	assign bus.scl_oe_n   = scl_q;
	assign bus.sda_m_o    = sda_q;
	assign bus.sda_m_oe_n = sda_q;
	assign cmd_ready      = rdy_q;
	assign wr_take        = take_q;
	assign rd_data        = rdat_q;
	assign rd_valid       = rdv_q;
	assign done           = done_q;
	assign nack_err       = err_q;
endmodule : twrs_master

// >>> hdl/twrs_device.sv
// Two-wire register slave: link side on the reference clock, register side on clock
`timescale 1ns/1ps
`include "twrs_consts.svh"
// Contract
// - Master starts with data fall, clock high
// - Data rise with clock high stops, idle
// - Eight bits MSB first, then acknowledge
// - One bit per clock, change only low
// - First byte: address high, direction bit zero
// - Default address 0x20/0x21, seven alternates
// - Select pins 000 to 111 decode
// - Acknowledge address only on match
// - Transmitter releases, receiver pulls low
// - No-acknowledge ends read, stop driving
// - Register address two bytes, high first
// - One data byte stored and acknowledged
// - Further write bytes go to next addresses
// - Pointer increments after each data byte
// - Random read uses dummy address write
// - Read without address uses current pointer
// - Master ack continues with next byte
// - Master ends read with nack, stop
// - Sequential read runs until count reached
// - Clock high eight, low six references
// - Serial clock is input only
module twrs_device (
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire logic                 external_ref_clock,
	twrs_if.device                    bus,
	input  wire logic [2:0]           address_select_pins,
	output logic                      reg_req,
	output logic                      reg_we,
	output twrs_pkg::twrs_addr_t      reg_addr,
	output twrs_pkg::twrs_byte_t      reg_wdata,
	input  wire twrs_pkg::twrs_byte_t reg_rdata
);
	import twrs_pkg::*;

	// Reference-clock domain
	logic         lrst_m, lrst_q;
	logic         scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
	logic [2:0]   sel_m, sel_s;
	logic         ack_m, ack_s, ack_p;
	logic         rise, fall, start, stop, load, rreq;
	logic [6:0]   own;
	twrs_dstate_t st_q, st_d;
	logic [3:0]   cnt_q, cnt_d;
	logic [1:0]   ph_q, ph_d;
	twrs_byte_t   sh_q, sh_d, tx_q, tx_d, rword_q, rword_d, rwd_q, rwd_d;
	twrs_addr_t   ptr_q, ptr_d, radr_q, radr_d;
	logic         rw_q, rw_d, rel_q, rel_d, mack_q, mack_d;
	logic         rtg_q, rtg_d, rwe_q, rwe_d;
	// Register-clock domain
	logic         rq_m, rq_s, rq_p;
	logic         req_q, req_d, we_q, we_d, fol_q, fol_d, atg_q, atg_d;
	twrs_addr_t   adr_q, adr_d;
	twrs_byte_t   wd_q, wd_d, rdat_q, rdat_d;

	// Reset level carried into the link domain
	always_ff @(posedge external_ref_clock) begin
		lrst_m <= rst;
		lrst_q <= lrst_m;
	end

	// Pins and returning toggle pass two flops first
	always_ff @(posedge external_ref_clock) begin
		if (lrst_q) begin
			scl_m <= 1'h1; scl_s <= 1'h1; scl_p <= 1'h1;
			sda_m <= 1'h1; sda_s <= 1'h1; sda_p <= 1'h1;
			sel_m <= 3'h0; sel_s <= 3'h0;
			ack_m <= 1'h0; ack_s <= 1'h0; ack_p <= 1'h0;
		end else begin
			scl_m <= bus.scl; scl_s <= scl_m; scl_p <= scl_s; // Only sampled
			sda_m <= bus.sda; sda_s <= sda_m; sda_p <= sda_s;
			sel_m <= address_select_pins; sel_s <= sel_m;
			ack_m <= atg_q; ack_s <= ack_m; ack_p <= ack_s;
		end
	end

	assign rise  = scl_s && !scl_p;
	assign fall  = !scl_s && scl_p;
	assign start = scl_s && scl_p && sda_p && !sda_s;
	assign stop  = scl_s && scl_p && !sda_p && sda_s;
	// Alternates step by eight from the base pair
	assign own   = `TWRS_ADDR_BASE + 7'(`TWRS_SEL_STEP * sel_s);

	always_comb begin
		st_d = st_q; cnt_d = cnt_q; ph_d = ph_q; sh_d = sh_q; tx_d = tx_q;
		ptr_d = ptr_q; rw_d = rw_q; rel_d = rel_q; mack_d = mack_q;
		rtg_d = rtg_q; rwe_d = rwe_q; radr_d = radr_q; rwd_d = rwd_q;
		load = 1'h0; rreq = 1'h0;
		rword_d = (ack_s ^ ack_p) ? rdat_q : rword_q;
		if (rise) begin
			cnt_d = cnt_q + 4'h1;
			sh_d = {sh_q[6:0], sda_s}; // MSB first
			if (st_q == D_MACK)
				mack_d = !sda_s;
		end
		if (start) begin
			st_d = D_ADDR; cnt_d = 4'h0; rel_d = 1'h1; // Restart allowed anywhere
		end else if (stop) begin
			st_d = D_IDLE; rel_d = 1'h1;
		end else if (fall) begin
			// All drive changes happen after a falling edge
			case (st_q)
				D_ADDR: begin
					if (cnt_q == `TWRS_BYTE_BITS) begin
						if (sh_q[7:1] == own) begin
							st_d = D_ACK; rel_d = 1'h0; rw_d = sh_q[0];
							ph_d = `TWRS_PHASE_HI;
							rreq = sh_q[0]; // Read from current pointer
						end else begin
							st_d = D_IGN;
						end
					end
				end
				D_RX: begin
					if (cnt_q == `TWRS_BYTE_BITS) begin
						st_d = D_ACK; rel_d = 1'h0;
						case (ph_q)
							`TWRS_PHASE_HI: ptr_d[15:8] = sh_q;
							`TWRS_PHASE_LO: ptr_d[7:0] = sh_q;
							default: begin
								// Store then advance
								rtg_d = !rtg_q; rwe_d = 1'h1; radr_d = ptr_q; rwd_d = sh_q;
								ptr_d = ptr_q + 16'h0001;
							end
						endcase
						if (ph_q != `TWRS_PHASE_DATA)
							ph_d = ph_q + 2'h1;
					end
				end
				D_ACK: begin
					cnt_d = 4'h0;
					if (rw_q) begin
						load = 1'h1;
					end else begin
						st_d = D_RX; rel_d = 1'h1;
					end
				end
				D_TX: begin
					if (cnt_q == `TWRS_BYTE_BITS) begin
						st_d = D_MACK; rel_d = 1'h1; cnt_d = 4'h0;
						rreq = 1'h1; // Prefetch next byte while master answers
					end else begin
						rel_d = tx_q[7]; tx_d = {tx_q[6:0], 1'h0};
					end
				end
				D_MACK: begin
					if (mack_q)
						load = 1'h1;
					else begin
						st_d = D_IGN; rel_d = 1'h1;
					end
				end
				default: ;
			endcase
		end
		if (load) begin
			st_d = D_TX; cnt_d = 4'h0; rel_d = rword_d[7];
			tx_d = {rword_d[6:0], 1'h0};
			ptr_d = ptr_q + 16'h0001;
		end
		if (rreq) begin
			rtg_d = !rtg_q; rwe_d = 1'h0; radr_d = ptr_d;
		end
	end

	always_ff @(posedge external_ref_clock) begin
		if (lrst_q) begin
			st_q <= D_IDLE; cnt_q <= 4'h0; ph_q <= `TWRS_PHASE_HI; sh_q <= 8'h00;
			tx_q <= 8'h00; ptr_q <= `TWRS_PTR_RESET; rw_q <= 1'h0; rel_q <= 1'h1;
			mack_q <= 1'h0; rtg_q <= 1'h0; rwe_q <= 1'h0; radr_q <= 16'h0000;
			rwd_q <= 8'h00; rword_q <= 8'h00;
		end else begin
			st_q <= st_d; cnt_q <= cnt_d; ph_q <= ph_d; sh_q <= sh_d;
			tx_q <= tx_d; ptr_q <= ptr_d; rw_q <= rw_d; rel_q <= rel_d;
			mack_q <= mack_d; rtg_q <= rtg_d; rwe_q <= rwe_d; radr_q <= radr_d;
			rwd_q <= rwd_d; rword_q <= rword_d;
		end
	end

	// Request toggle crosses; its words stay still until answered
	always_ff @(posedge clock) begin
		if (rst) begin
			rq_m <= 1'h0; rq_s <= 1'h0; rq_p <= 1'h0;
		end else begin
			rq_m <= rtg_q; rq_s <= rq_m; rq_p <= rq_s;
		end
	end

	always_comb begin
		req_d = rq_s ^ rq_p;
		we_d = req_d ? rwe_q : we_q;
		adr_d = req_d ? radr_q : adr_q;
		wd_d = req_d ? rwd_q : wd_q;
		fol_d = req_q;
		rdat_d = fol_q ? reg_rdata : rdat_q;
		atg_d = fol_q ? !atg_q : atg_q;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			req_q <= 1'h0; we_q <= 1'h0; adr_q <= 16'h0000; wd_q <= 8'h00;
			fol_q <= 1'h0; rdat_q <= 8'h00; atg_q <= 1'h0;
		end else begin
			req_q <= req_d; we_q <= we_d; adr_q <= adr_d; wd_q <= wd_d;
			fol_q <= fol_d; rdat_q <= rdat_d; atg_q <= atg_d;
		end
	end

	// Open drain: value and enable share one flop
	assign bus.sda_d_o    = rel_q;
	assign bus.sda_d_oe_n = rel_q;
	assign reg_req        = req_q;
	assign reg_we         = we_q;
	assign reg_addr       = adr_q;
	assign reg_wdata      = wd_q;
endmodule : twrs_device

// >>> verif/twrs_properties.sv
// Link protocol checks beside the interface joining master and device
`timescale 1ns/1ps
module twrs_properties (
	input wire logic clock,
	input wire logic rst,
	input wire logic external_ref_clock,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_d_o,
	input wire logic sda_d_oe_n
);
	chk_dev_edge_low: assert property (@(posedge external_ref_clock) disable iff (rst)
		$changed(sda_d_oe_n) |-> !scl) else $error("device data moved with clock high");
	logic [3:0] bit_q;
	logic       first_q;
	// Rises since the last start; the first byte belongs to the master alone
	always_ff @(posedge clock) begin
		if (rst || (scl && $fell(sda))) begin
			bit_q   <= 4'h0;
			first_q <= 1'h1;
		end else if ($rose(scl)) begin
			bit_q   <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
			first_q <= first_q && (bit_q != 4'h8);
		end
	end
	chk_dev_addr_quiet: assert property (@(posedge clock) disable iff (rst)
		$rose(scl) && first_q && bit_q != 4'h8 |-> sda_d_oe_n && sda_d_o)
		else $error("device drove data during the address byte");
	chk_dev_ack_late: assert property (@(posedge external_ref_clock) disable iff (rst)
		$fell(sda_d_oe_n) |-> !$past(scl, 1) && !$past(scl, 2))
		else $error("device pulled data before the synchronised clock fall");
	chk_stop_release: assert property (@(posedge external_ref_clock) disable iff (rst)
		scl && $rose(sda) |-> sda_d_oe_n [*8]) else $error("device drove data after stop");
	chk_start_hold: assert property (@(posedge clock) disable iff (rst)
		scl && $fell(sda) |-> scl [*4]) else $error("clock fell too soon after start");
	chk_stop_free: assert property (@(posedge clock) disable iff (rst)
		scl && $rose(sda) |-> sda [*8]) else $error("bus not idle after stop");
	// 8 reference periods of 64 ns need 6 samples at 100 ns
	chk_scl_high_min: assert property (@(posedge clock) disable iff (rst)
		$rose(scl) |-> scl [*6]) else $error("serial clock high too short");
	chk_scl_low_min: assert property (@(posedge clock) disable iff (rst)
		$fell(scl) |-> !scl [*4]) else $error("serial clock low too short");
	cover property (@(posedge clock) disable iff (rst) scl && $fell(sda));
	cover property (@(posedge external_ref_clock) disable iff (rst) $fell(sda_d_oe_n));
	cover property (@(posedge clock) disable iff (rst) scl && $rose(sda));
endmodule : twrs_properties

// >>> verif/testbench.sv
// Self-checking bench: master and device joined across the link
`timescale 1ns/1ps
module testbench;
	import twrs_pkg::*;
	logic       clock = 1'h0;
	logic       external_ref_clock = 1'h0;
	logic       rst = 1'h1;
	logic       cmd_valid = 1'h0;
	logic       cmd_read = 1'h0;
	logic       cmd_random = 1'h0;
	logic [6:0] cmd_dev = 7'h00;
	logic [7:0] cmd_len = 8'h01;
	logic [2:0] sel = 3'h0;
	logic       cmd_ready, wr_take, rd_valid, done, nack_err, reg_req, reg_we;
	twrs_addr_t cmd_reg = 16'h0000;
	twrs_addr_t reg_addr, a;
	twrs_addr_t ptr = 16'h0000;
	twrs_byte_t wr_data = 8'h00;
	twrs_byte_t reg_rdata = 8'h00;
	twrs_byte_t rd_data, reg_wdata;
	twrs_byte_t wbuf [0:255];
	twrs_byte_t mem [twrs_addr_t];
	twrs_byte_t emem [twrs_addr_t];
	twrs_byte_t rq [$];
	logic [23:0] wq [$];
	logic [31:0] seed = 32'h19A0;
	logic [6:0] dev;
	int         widx = 0;
	int         n_mismatch = 0;
	int         n_checks = 0;
	always #50 clock = ~clock;
	always #32 external_ref_clock = ~external_ref_clock;
	twrs_if bus_if ();
	twrs_master #(.QTR(6)) twrs_master_inst (.clock(clock), .rst(rst), .bus(bus_if),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
		.cmd_random(cmd_random), .cmd_dev(cmd_dev), .cmd_reg(cmd_reg), .cmd_len(cmd_len),
		.wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
		.done(done), .nack_err(nack_err));
	twrs_device twrs_device_inst (.clock(clock), .rst(rst),
		.external_ref_clock(external_ref_clock), .bus(bus_if), .address_select_pins(sel),
		.reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata));
	twrs_properties twrs_properties_inst (.clock(clock), .rst(rst),
		.external_ref_clock(external_ref_clock), .scl(bus_if.scl), .sda(bus_if.sda),
		.sda_d_o(bus_if.sda_d_o), .sda_d_oe_n(bus_if.sda_d_oe_n));
	function automatic logic [31:0] lfsr();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : lfsr
	function automatic twrs_byte_t pat(input twrs_addr_t x);
		return x[7:0] ^ x[15:8] ^ 8'h5A;
	endfunction : pat
	// Unwritten places read back a pattern, so reads never match by luck
	function automatic twrs_byte_t expv(input twrs_addr_t x);
		return emem.exists(x) ? emem[x] : pat(x);
	endfunction : expv
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	// Register side: answers one cycle after each request, prefetches included
	always @(posedge clock) begin
		if (reg_req === 1'h1 && reg_we === 1'h1) begin
			mem[reg_addr] = reg_wdata;
			check({reg_addr, reg_wdata}, wq.size() ? wq.pop_front() : 24'hXXXXXX, "write");
		end
		if (reg_req === 1'h1) reg_rdata <= #1 mem.exists(reg_addr) ? mem[reg_addr] : pat(reg_addr);
		if (wr_take === 1'h1) begin
			widx++;
			wr_data <= #1 wbuf[widx[7:0]];
		end
		if (rd_valid === 1'h1) check(24'(rd_data), rq.size() ? 24'(rq.pop_front()) : 24'hX, "read");
	end
	task automatic run(input logic rd, input logic rnd, input logic [6:0] d, input twrs_addr_t ra,
		input logic [7:0] len, input logic exp_nack);
		int k;
		widx = 0;
		wr_data = wbuf[0];
		cmd_read = rd;
		cmd_random = rnd;
		cmd_dev = d;
		cmd_reg = ra;
		cmd_len = len;
		cmd_valid = 1'h1;
		k = 0;
		while (cmd_ready !== 1'h1 && k < 100) begin
			@(posedge clock);
			#1 k++;
		end
		if (k >= 100) begin
			n_mismatch++;
			conclude();
		end
		@(posedge clock);
		#1 cmd_valid = 1'h0;
		k = 0;
		while (done !== 1'h1 && k < 20000) begin
			@(posedge clock);
			#1 k++;
		end
		if (k >= 20000) begin
			n_mismatch++;
			conclude();
		end
		check(24'(nack_err), 24'(exp_nack), "address ack");
	endtask : run
	initial begin
		repeat (16) @(posedge clock);
		#1 rst = 1'h0;
		for (int i = 0; i < 3; i++) begin
			sel = (i == 2) ? 3'(lfsr()) : 3'(i);
			dev = 7'h10 + {1'h0, sel, 3'h0};
			repeat (4) @(posedge clock);
			#1 a = 16'(lfsr());
			for (int j = 0; j < 3; j++) begin
				wbuf[j] = 8'(lfsr());
				emem[a + 16'(j)] = wbuf[j];
				wq.push_back({a + 16'(j), wbuf[j]});
			end
			run(1'h0, 1'h0, dev, a, 8'h03, 1'h0);
			rq.push_back(expv(a + 16'h0002));
			rq.push_back(expv(a + 16'h0003));
			run(1'h1, 1'h1, dev, a + 16'h0002, 8'h02, 1'h0);
			ptr = a + 16'h0004;
			// Wrong address must leave the pointer alone
			run(1'h0, 1'h0, dev ^ 7'h01, a, 8'h01, 1'h1);
			rq.push_back(expv(ptr));
			run(1'h1, 1'h0, dev, 16'h0000, 8'h01, 1'h0);
		end
		check(24'(wq.size() + rq.size()), 24'h0, "left over");
		conclude();
	end
endmodule : testbench
